// file: design/dma_ram_pkg.sv
package dma_ram_pkg;

	// Array geometry: 2 KB of 16-bit words, byte addressed
	localparam int RAM_BYTES = 2048;
	localparam int ADDR_W = 16;
	localparam int WORD_W = 16;
	localparam int WORDS = RAM_BYTES / 2;
	localparam int IDX_W = $clog2(WORDS);

	// Region sits at the top of the Y data space; base must be 2 KB aligned
	localparam logic [ADDR_W-1:0] RAM_BASE = 16'h7800;
	localparam logic [ADDR_W-1:0] RAM_MASK = 16'hF800;

	// Reset value of each read-data output
	localparam logic [WORD_W-1:0] RDATA_RST = 16'h0000;

	// One access request from a master
	typedef struct packed {
		logic en;
		logic we;
		logic byte_op;
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] wdata;
	} ram_req_t;

endpackage

// file: design/dma_ram_port.sv
`timescale 1ns/10ps
`default_nettype none

// Per-port decode: hit test, word index and byte-lane write enables
module dma_ram_port
	import dma_ram_pkg::*;
(
	input wire ram_req_t req,
	output logic hit,
	output logic [IDX_W-1:0] idx,
	output logic [1:0] lane_we,
	output logic [WORD_W-1:0] wword
);

	// Region decode within the Y space
	assign hit = req.en && ((req.addr & RAM_MASK) == RAM_BASE);
	assign idx = req.addr[IDX_W:1];

	// Byte op picks its lane from address bit 0; word op writes both
	assign lane_we[0] = hit && req.we && (!req.byte_op || !req.addr[0]);
	assign lane_we[1] = hit && req.we && (!req.byte_op || req.addr[0]);

	// Byte data arrives in the low byte and is replicated to both lanes
	assign wword = req.byte_op ? {req.wdata[7:0], req.wdata[7:0]} : req.wdata;

endmodule // dma_ram_port

`default_nettype wire

// file: design/dual_port_dma_ram.sv
`timescale 1ns/10ps
`default_nettype none

// How it works
// RULE_01: Two kilobytes of RAM decoded at the top of the Y data space.
// RULE_02: CPU and DMA ports are served in the same cycle, independently.
// RULE_03: DMA port reads and writes buffers for both transfer directions.
// RULE_04: DMA accesses take no CPU cycles and never delay the CPU.
// RULE_05: On a same-word write collision the CPU write takes precedence.
// RULE_06: The CPU port has no wait or stall signal at all.
// RULE_07: Without DMA, CPU uses the region as ordinary data memory.
// RULE_08: 16-bit words, low byte at even address, high byte at odd.
// RULE_09: A byte write changes only the lane chosen by address bit 0.
// RULE_10: On collision CPU-written lanes keep CPU data; only those DMA lanes are dropped silently.
module dual_port_dma_ram
	import dma_ram_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire ram_req_t cpu_req,
	output logic [WORD_W-1:0] cpu_rdata,
	output logic cpu_rvalid,
	input wire ram_req_t dma_req,
	output logic [WORD_W-1:0] dma_rdata,
	output logic dma_rvalid
);

	logic [WORD_W-1:0] mem [WORDS];
	logic cpu_hit, dma_hit;
	logic [IDX_W-1:0] cpu_idx, dma_idx;
	logic [1:0] cpu_lane, dma_lane, dma_lane_eff;
	logic [WORD_W-1:0] cpu_word, dma_word;
	logic [WORD_W-1:0] cpu_rdata_d, dma_rdata_d;
	logic cpu_rvalid_q, dma_rvalid_q;
	logic [WORD_W-1:0] cpu_rdata_q, dma_rdata_q;

	// Independent decoders per port
	dma_ram_port u_cpu_dec (
		.req(cpu_req),
		.hit(cpu_hit),
		.idx(cpu_idx),
		.lane_we(cpu_lane),
		.wword(cpu_word)
	);

	dma_ram_port u_dma_dec (
		.req(dma_req),
		.hit(dma_hit),
		.idx(dma_idx),
		.lane_we(dma_lane),
		.wword(dma_word)
	);

	// Lane-wise collision mask: CPU lane wins, other lane of DMA still lands
	wire same_word = cpu_idx == dma_idx;
	assign dma_lane_eff = same_word ? (dma_lane & ~cpu_lane) : dma_lane; // RULE_05 RULE_10

	// Byte lane select on read: byte ops return selected byte in low byte
	function automatic logic [WORD_W-1:0] rd_sel(input logic [WORD_W-1:0] w,
		input logic byte_op, input logic a0);
		rd_sel = byte_op ? {8'h00, (a0 ? w[15:8] : w[7:0])} : w; // RULE_08
	endfunction

	// Read data of the current contents; out-of-region reads give zero
	assign cpu_rdata_d = cpu_hit ? rd_sel(mem[cpu_idx], cpu_req.byte_op, cpu_req.addr[0])
		: RDATA_RST; // RULE_01 RULE_07
	assign dma_rdata_d = dma_hit ? rd_sel(mem[dma_idx], dma_req.byte_op, dma_req.addr[0])
		: RDATA_RST; // RULE_03

	// Array write: DMA first, CPU last so the CPU lane dominates
	// Array holds no reset; content is undefined after power-up as in any RAM
	always_ff @(posedge clk)
	begin
		if (dma_lane_eff[0]) mem[dma_idx][7:0] <= dma_word[7:0]; // RULE_03 RULE_09
		if (dma_lane_eff[1]) mem[dma_idx][15:8] <= dma_word[15:8]; // RULE_09
		if (cpu_lane[0]) mem[cpu_idx][7:0] <= cpu_word[7:0]; // RULE_02 RULE_09
		if (cpu_lane[1]) mem[cpu_idx][15:8] <= cpu_word[15:8]; // RULE_02 RULE_09
	end

	// Read registers: one cycle latency on both ports, no wait path
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cpu_rdata_q <= RDATA_RST;
			dma_rdata_q <= RDATA_RST;
			cpu_rvalid_q <= 1'b0;
			dma_rvalid_q <= 1'b0;
		end
		else
		begin
			cpu_rdata_q <= cpu_rdata_d; // RULE_02 RULE_06
			dma_rdata_q <= dma_rdata_d; // RULE_04
			cpu_rvalid_q <= cpu_req.en && !cpu_req.we;
			dma_rvalid_q <= dma_req.en && !dma_req.we;
		end
	end

	assign cpu_rdata = cpu_rdata_q;
	assign dma_rdata = dma_rdata_q;
	assign cpu_rvalid = cpu_rvalid_q;
	assign dma_rvalid = dma_rvalid_q;

	// Assertion helpers: track a collision with a CPU word write in the last cycle
	logic col_q;
	logic [IDX_W-1:0] col_idx_q;
	logic [WORD_W-1:0] col_word_q;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			col_q <= 1'b0;
			col_idx_q <= '0;
			col_word_q <= '0;
		end
		else
		begin
			col_q <= same_word && (cpu_lane == 2'b11) && (dma_lane != 2'b00);
			col_idx_q <= cpu_idx;
			col_word_q <= cpu_word;
		end
	end

	property p_cpu_wins;
		@(posedge clk) disable iff (!nrst) col_q |-> mem[col_idx_q] == col_word_q;
	endproperty
	a_cpu_wins: assert property (p_cpu_wins) else $error("cpu lost collision"); // RULE_05

	property p_dma_dropped;
		@(posedge clk) disable iff (!nrst)
			(cpu_hit && dma_hit && same_word && cpu_req.we && dma_req.we
			&& !cpu_req.byte_op) |-> dma_lane_eff == 2'b00;
	endproperty
	a_dma_dropped: assert property (p_dma_dropped) else $error("dma write not dropped"); // RULE_10

	property p_cpu_read_latency;
		@(posedge clk) disable iff (!nrst)
			(cpu_req.en && !cpu_req.we) |=> cpu_rvalid;
	endproperty
	a_cpu_read_latency: assert property (p_cpu_read_latency) else $error("cpu read late"); // RULE_06

	property p_dma_read_latency;
		@(posedge clk) disable iff (!nrst)
			(dma_req.en && !dma_req.we) |=> dma_rvalid;
	endproperty
	a_dma_read_latency: assert property (p_dma_read_latency) else $error("dma read late"); // RULE_04

	property p_cpu_word_write;
		@(posedge clk) disable iff (!nrst)
			(cpu_hit && cpu_req.we && !cpu_req.byte_op) |=> mem[$past(cpu_idx)] == $past(cpu_word);
	endproperty
	a_cpu_word_write: assert property (p_cpu_word_write) else $error("cpu write lost"); // RULE_07

	property p_dma_word_write;
		@(posedge clk) disable iff (!nrst)
			(dma_hit && dma_req.we && !dma_req.byte_op && !(cpu_hit && cpu_req.we && same_word))
			|=> mem[$past(dma_idx)] == $past(dma_word);
	endproperty
	a_dma_word_write: assert property (p_dma_word_write) else $error("dma write lost"); // RULE_03

	property p_byte_keeps_other;
		@(posedge clk) disable iff (!nrst)
			(cpu_hit && cpu_req.we && cpu_req.byte_op && !cpu_req.addr[0] && !dma_hit)
			|=> mem[$past(cpu_idx)][15:8] == $past(mem[cpu_idx][15:8]);
	endproperty
	a_byte_keeps_other: assert property (p_byte_keeps_other) else $error("byte write spill"); // RULE_09

	property p_miss_reads_zero;
		@(posedge clk) disable iff (!nrst)
			(cpu_req.en && !cpu_req.we && !cpu_hit) |=> cpu_rdata == RDATA_RST;
	endproperty
	a_miss_reads_zero: assert property (p_miss_reads_zero) else $error("miss not zero"); // RULE_01

	property p_high_byte_read;
		@(posedge clk) disable iff (!nrst)
			(cpu_hit && !cpu_req.we && cpu_req.byte_op && cpu_req.addr[0])
			|=> cpu_rdata == {8'h00, $past(mem[cpu_idx][15:8])};
	endproperty
	a_high_byte_read: assert property (p_high_byte_read) else $error("odd byte wrong"); // RULE_08

	// Valid stuck high would pass the latency checks, so pin down the idle side too
	property p_cpu_idle_nv;
		@(posedge clk) disable iff (!nrst)
			!(cpu_req.en && !cpu_req.we) |=> !cpu_rvalid;
	endproperty
	a_cpu_idle_nv: assert property (p_cpu_idle_nv) else $error("cpu stray valid"); // RULE_06

	property p_dma_idle_nv;
		@(posedge clk) disable iff (!nrst)
			!(dma_req.en && !dma_req.we) |=> !dma_rvalid;
	endproperty
	a_dma_idle_nv: assert property (p_dma_idle_nv) else $error("dma stray valid"); // RULE_04

	// DMA port decodes the same region as the CPU port
	property p_dma_miss_zero;
		@(posedge clk) disable iff (!nrst)
			(dma_req.en && !dma_req.we && !dma_hit) |=> dma_rdata == RDATA_RST;
	endproperty
	a_dma_miss_zero: assert property (p_dma_miss_zero) else $error("dma miss not zero"); // RULE_01

	// Byte collision: CPU lane still wins over a DMA write to the same word
	property p_cpu_byte_wins;
		@(posedge clk) disable iff (!nrst)
			(cpu_lane == 2'b01 && dma_hit && dma_req.we && same_word)
			|=> mem[$past(cpu_idx)][7:0] == $past(cpu_word[7:0]);
	endproperty
	a_cpu_byte_wins: assert property (p_cpu_byte_wins) else $error("cpu byte lost"); // RULE_05

	// Lane the CPU leaves alone still takes the DMA byte
	property p_dma_lane_lands;
		@(posedge clk) disable iff (!nrst)
			(cpu_lane == 2'b01 && dma_lane == 2'b11 && same_word)
			|=> mem[$past(dma_idx)][15:8] == $past(dma_word[15:8]);
	endproperty
	a_dma_lane_lands: assert property (p_dma_lane_lands) else $error("dma lane lost"); // RULE_09

	property p_dma_even_read;
		@(posedge clk) disable iff (!nrst)
			(dma_hit && !dma_req.we && dma_req.byte_op && !dma_req.addr[0])
			|=> dma_rdata == {8'h00, $past(mem[dma_idx][7:0])};
	endproperty
	a_dma_even_read: assert property (p_dma_even_read) else $error("even byte wrong"); // RULE_08

	c_collision: cover property (@(posedge clk) disable iff (!nrst) col_q);
	c_both_read: cover property (@(posedge clk) disable iff (!nrst) cpu_rvalid && dma_rvalid);
	c_dma_write: cover property (@(posedge clk) disable iff (!nrst) dma_hit && dma_req.we);
	c_byte_collision: cover property (@(posedge clk) disable iff (!nrst)
		cpu_lane == 2'b01 && dma_hit && dma_req.we && same_word);
	c_miss_read: cover property (@(posedge clk) disable iff (!nrst)
		cpu_req.en && !cpu_req.we && !cpu_hit);

endmodule // dual_port_dma_ram

`default_nettype wire

// file: verification/dma_master_model.sv
`timescale 1ns/10ps
`default_nettype none

// DMA side master: launches each command just after the clock edge
module dma_master_model
	import dma_ram_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire ram_req_t cmd,
	output var ram_req_t req
);
	// Idle lines are inverted, so a stale address can never pass for a live one
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			req <= '0;
		else if (cmd.en)
			req <= cmd;
		else
			req <= ram_req_t'({1'b0, ~req[$bits(ram_req_t)-2:0]});
	end
endmodule // dma_master_model

`default_nettype wire

// file: verification/tb_dual_port_dma_ram.sv
`timescale 1ns/10ps
`default_nettype none

module tb_dual_port_dma_ram;
	import dma_ram_pkg::*;
	logic clk, nrst, cv = 1'b0, dv = 1'b0;
	logic [WORD_W-1:0] cpu_rdata, dma_rdata, cd, dd;
	logic cpu_rvalid, dma_rvalid;
	logic [31:0] seed;
	logic [7:0] mem [RAM_BYTES];
	ram_req_t cpu_req, dma_cmd, dma_req;
	int num_errors = 0, n_tests = 0;

	dual_port_dma_ram dut (.clk(clk), .nrst(nrst), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
		.cpu_rvalid(cpu_rvalid), .dma_req(dma_req), .dma_rdata(dma_rdata), .dma_rvalid(dma_rvalid));
	dma_master_model dma (.clk(clk), .nrst(nrst), .cmd(dma_cmd), .req(dma_req));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	// Mostly a 16-byte window so the ports collide often; also the top and just below
	function automatic ram_req_t mk(input logic [31:0] r, input ram_req_t prev);
		ram_req_t q;
		q = ram_req_t'({r[0] | r[1], r[2], r[3], 16'h7800 | {12'h000, r[11:8]}, r[31:16]});
		if (r[7:4] == 4'h0)
			q.addr = {12'h77F, r[11:8]};
		if (r[7:4] == 4'hF)
			q.addr = {12'h7FF, r[11:8]};
		if (!q.en)
			q = ram_req_t'({1'b0, ~prev[$bits(ram_req_t)-2:0]});
		return q;
	endfunction

	function automatic logic hit(input ram_req_t q);
		return q.en && ((q.addr & RAM_MASK) == RAM_BASE);
	endfunction

	// Reference read: byte lands in the low lane, misses read zero
	function automatic logic [15:0] rd(input ram_req_t q);
		logic [IDX_W:0] a;
		a = q.addr[IDX_W:0];
		if (!hit(q))
			return 16'h0000;
		if (q.byte_op)
			return {8'h00, mem[a]};
		return {mem[{a[IDX_W:1], 1'b1}], mem[{a[IDX_W:1], 1'b0}]};
	endfunction

	task automatic wr(input ram_req_t q);
		logic [IDX_W:0] a;
		a = q.addr[IDX_W:0];
		if (hit(q) && q.we && q.byte_op)
			mem[a] = q.wdata[7:0];
		if (hit(q) && q.we && !q.byte_op)
			{mem[{a[IDX_W:1], 1'b1}], mem[{a[IDX_W:1], 1'b0}]} = q.wdata;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Answers of the last edge first, then the requests taken now; DMA lanes before CPU
	always @(posedge clk)
	begin
		chk(16'(cpu_rvalid), 16'(cv), "cpu rvalid");
		chk(16'(dma_rvalid), 16'(dv), "dma rvalid");
		if (cv)
			chk(cpu_rdata, cd, "cpu rdata");
		if (dv)
			chk(dma_rdata, dd, "dma rdata");
		cv = nrst && cpu_req.en && !cpu_req.we;
		dv = nrst && dma_req.en && !dma_req.we;
		cd = rd(cpu_req);
		dd = rd(dma_req);
		if (nrst)
			wr(dma_req);
		if (nrst)
			wr(cpu_req);
	end

	initial
	begin
		#80000;
		num_errors++;
		summarize();
	end

	initial
	begin
		// Start high and fall at 1 ns so the asynchronous reset sees a real edge
		nrst = 1'b1;
		cpu_req = '0;
		dma_cmd = '0;
		seed = 32'h00017995;
		#1 nrst = 1'b0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		// Fill then cross-read: each port reads what the other stored
		for (int p = 0; p < 2; p++)
		begin
			for (int i = 0; i < WORDS / 2; i++)
			begin
				@(posedge clk);
				seed = xs(seed);
				cpu_req <= ram_req_t'({1'b1, p == 0, 1'b0, RAM_BASE | ADDR_W'(2 * i + p * WORDS), seed[15:0]});
				dma_cmd <= ram_req_t'({1'b1, p == 0, 1'b0, RAM_BASE | ADDR_W'(2 * i + WORDS - p * WORDS), seed[31:16]});
			end
		end
		$display("fill and cross-read test done");
		repeat (3000)
		begin
			@(posedge clk);
			seed = xs(seed);
			cpu_req <= mk(seed, cpu_req);
			seed = xs(seed);
			dma_cmd <= mk(seed, dma_cmd);
		end
		$display("random collision test done");
		// DMA model adds a cycle, so its last answer lands one edge after the CPU's
		repeat (5) @(posedge clk);
		summarize();
	end
endmodule // tb_dual_port_dma_ram

`default_nettype wire
